// *** core/kaw_keypad_wake.v ***
// Keypad interrupt unit with auto wakeup timer behind an AXI4-Lite slave
// Summary of operation
// - Pending flag reads 1 when request latched
// - Acknowledge clears both latches, reads zero
// - Mask bit blocks request to CPU
// - Sensitivity selects edge or edge-plus-level
// - Six pin enables, one shared mask
// - Pullup engaged on keyboard-enabled pins
// - Keypad request drives wakeup output
// - Wake source has own enable, shares mask
// - Wake request ends stop without pins
// - Period select 1 picks short timeout
// - Wake timer runs on a clk divider standing in for its own oscillator
// - Port data bit six shows wake latch
// - Bit six has no pin, direction, pullup
// - Wake enable gates latch set; reset clears
// - Sensitivity ignored by wake requests
`timescale 1ns/1ps
`include "kaw_regs.vh"

module kaw_keypad_wake #(
    parameter integer NPINS        = 6,
    parameter integer OSC_DIV      = 7813,
    parameter integer SHORT_TICKS  = (`KAW_SHORT_US * `KAW_OSC_KHZ) / 1000,
    parameter integer LONG_TICKS   = (`KAW_LONG_US * `KAW_OSC_KHZ) / 1000
) (
    input  wire              clk,
    input  wire              reset,
    input  wire [NPINS-1:0]  key_pin,
    output wire [NPINS-1:0]  key_pullup_en,
    output wire              cpu_irq,
    output wire              wake_from_stop,
    output wire              irq,
    input  wire [11:0]       s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output wire [1:0]        s_axi_bresp,
    output wire              s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [11:0]       s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output wire [31:0]       s_axi_rdata,
    output wire [1:0]        s_axi_rresp,
    output wire              s_axi_rvalid,
    input  wire              s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    reg  [NPINS-1:0] pin_en_reg;
    reg              wake_irq_enable_reg;
    reg              request_mask_reg;
    reg              trigger_sensitivity_reg;
    reg              wake_period_select_reg;
    reg              key_latch_reg;
    reg              wake_request_latch_reg;
    reg  [NPINS-1:0] pin_prev_reg;
    reg  [1:0]       irq_status_reg;
    reg  [1:0]       irq_mask_reg;
    reg  [12:0]      osc_div_reg;
    reg  [19:0]      wake_cnt_reg;
    reg              ack_pulse_reg;

    // AXI slave state
    reg  [11:0] awaddr_reg;
    reg         aw_held_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg         w_held_reg;
    reg         bvalid_reg;
    reg  [1:0]  bresp_reg;
    reg         rvalid_reg;
    reg  [31:0] rdata_reg;
    reg  [1:0]  rresp_reg;

    function [7:0] word_index;
        input [11:0] addr;
        begin
            word_index = addr[9:2];
        end
    endfunction

    function mapped;
        input [7:0] idx;
        begin
            mapped = (idx == `KAW_IDX_PORT_DATA) || (idx == `KAW_IDX_STATUS_CTRL)
                  || (idx == `KAW_IDX_ENABLE) || (idx == `KAW_IDX_IRQ_STATUS)
                  || (idx == `KAW_IDX_IRQ_MASK) || (idx == `KAW_IDX_WAKE_CFG)
                  || (idx == `KAW_IDX_PIN_IN);
        end
    endfunction

    localparam [1:0] RESP_OKAY   = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;

    // Unmapped indices answer SLVERR on both channels
    function [1:0] resp_for;
        input [7:0] idx;
        begin
            resp_for = mapped(idx) ? RESP_OKAY : RESP_SLVERR;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Keypad trigger logic
    // Prev sample starts high so reset never fakes an edge
    wire [NPINS-1:0] falling   = pin_prev_reg & ~key_pin & pin_en_reg;
    wire [NPINS-1:0] low_level = ~key_pin & pin_en_reg;
    wire key_set   = (|falling) || (trigger_sensitivity_reg && (|low_level));

    // Oscillator tick stands in for the separate low-power clock
    wire osc_tick  = (osc_div_reg == OSC_DIV[12:0] - 13'h0001);
    wire [19:0] wake_limit = wake_period_select_reg ? SHORT_TICKS[19:0]
                                                    : LONG_TICKS[19:0];
    wire wake_timeout = osc_tick && (wake_cnt_reg >= wake_limit - 20'h0_0001);
    // Timer keeps counting while wake is disabled; only the latch set and the wake status bit set are gated
    wire wake_set  = wake_timeout && wake_irq_enable_reg;

    // Mask gates only the CPU line and wake_from_stop; the pending flag still shows
    wire any_req   = key_latch_reg | wake_request_latch_reg;
    assign cpu_irq        = any_req & ~request_mask_reg;
    assign wake_from_stop = cpu_irq;
    assign key_pullup_en  = pin_en_reg;

    ////////////////////////////////////////////////////////////////////////////
    // AXI write path
    // Address and data may come in either order; each is parked until both are here
    wire aw_ok = aw_held_reg || s_axi_awvalid;
    wire w_ok  = w_held_reg  || s_axi_wvalid;
    wire [11:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg  ? wdata_reg  : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_reg  ? wstrb_reg  : s_axi_wstrb;
    wire do_write = aw_ok && w_ok && !bvalid_reg;
    wire [7:0] wr_idx = word_index(wr_addr);
    wire wr_lane0 = do_write && wr_strb[0];

    // One strobe per register keeps the decode in one place
    wire wr_sc   = wr_lane0 && (wr_idx == `KAW_IDX_STATUS_CTRL);
    wire wr_en   = wr_lane0 && (wr_idx == `KAW_IDX_ENABLE);
    wire wr_wcfg = wr_lane0 && (wr_idx == `KAW_IDX_WAKE_CFG);
    wire wr_imsk = wr_lane0 && (wr_idx == `KAW_IDX_IRQ_MASK);

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always @(posedge clk)
    begin
        if (reset)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 12'h000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'b00;
        end
        else
        begin
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= resp_for(wr_idx);
            end
            else
            begin
                if (s_axi_awvalid && s_axi_awready)
                begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    w_held_reg <= 1'b1;
                    wdata_reg  <= s_axi_wdata;
                    wstrb_reg  <= s_axi_wstrb;
                end
                if (bvalid_reg && s_axi_bready)
                    bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    // Ack is a one-cycle strobe, never stored as a readable bit
    always @(posedge clk)
    begin
        if (reset)
        begin
            pin_en_reg              <= {NPINS{1'b0}};
            wake_irq_enable_reg     <= 1'b0;
            request_mask_reg        <= 1'b0;
            trigger_sensitivity_reg <= 1'b0;
            wake_period_select_reg  <= 1'b0;
            irq_mask_reg            <= 2'b00;
            ack_pulse_reg           <= 1'b0;
        end
        else
        begin
            ack_pulse_reg <= 1'b0;
            if (wr_sc)
            begin
                request_mask_reg        <= wr_data[`KAW_SC_MASK];
                trigger_sensitivity_reg <= wr_data[`KAW_SC_SENS];
                ack_pulse_reg           <= wr_data[`KAW_SC_ACK];
            end
            if (wr_en)
            begin
                pin_en_reg          <= wr_data[NPINS-1:0];
                wake_irq_enable_reg <= wr_data[`KAW_EN_WAKE];
            end
            if (wr_wcfg)
                wake_period_select_reg <= wr_data[0];
            if (wr_imsk)
                irq_mask_reg <= wr_data[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request latches and wake timer
    reg              key_latch_next;
    reg              wake_request_latch_next;
    reg  [12:0]      osc_div_next;
    reg  [19:0]      wake_cnt_next;

    // Set wins over acknowledge; a held low level re-sets at once
    always @*
    begin
        key_latch_next = key_latch_reg;
        if (key_set)
            key_latch_next = 1'b1;
        else if (ack_pulse_reg)
            key_latch_next = 1'b0;
    end

    // Wake path never looks at the sensitivity bit
    always @*
    begin
        wake_request_latch_next = wake_request_latch_reg;
        if (wake_set)
            wake_request_latch_next = 1'b1;
        else if (ack_pulse_reg)
            wake_request_latch_next = 1'b0;
    end

    // Divider tick stands in for the slow oscillator edge
    always @*
    begin
        osc_div_next  = osc_div_reg + 13'h0001;
        wake_cnt_next = wake_cnt_reg;
        if (osc_tick)
        begin
            osc_div_next = 13'h0000;
            if (wake_timeout)
                wake_cnt_next = 20'h0_0000;
            else
                wake_cnt_next = wake_cnt_reg + 20'h0_0001;
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            pin_prev_reg           <= {NPINS{1'b1}};
            key_latch_reg          <= 1'b0;
            wake_request_latch_reg <= 1'b0;
            osc_div_reg            <= 13'h0000;
            wake_cnt_reg           <= 20'h0_0000;
        end
        else
        begin
            pin_prev_reg           <= key_pin;
            key_latch_reg          <= key_latch_next;
            wake_request_latch_reg <= wake_request_latch_next;
            osc_div_reg            <= osc_div_next;
            wake_cnt_reg           <= wake_cnt_next;
        end
    end
    // Wake latch is independent of pins so stop can end on its own

    ////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, cleared by reading it
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [7:0] rd_idx = word_index(s_axi_araddr);
    wire clr_status = rd_take && rd_idx == `KAW_IDX_IRQ_STATUS;
    wire [1:0] events = {wake_set, key_set};

    reg  [1:0] irq_status_next;

    // Set wins over the read clear
    always @*
    begin
        irq_status_next = events | (clr_status ? 2'b00 : irq_status_reg);
    end

    always @(posedge clk)
    begin
        if (reset)
            irq_status_reg <= 2'b00;
        else
            irq_status_reg <= irq_status_next;
    end
    assign irq = |(irq_status_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // AXI read path
    // Unmapped indices read zero
    reg [7:0] rd_byte;
    always @*
    begin
        rd_byte = 8'h00;
        case (rd_idx)
            `KAW_IDX_PORT_DATA:   rd_byte = {1'b0, wake_request_latch_reg, 6'h00};
            `KAW_IDX_STATUS_CTRL: rd_byte = {4'h0, key_latch_reg | wake_request_latch_reg,
                                           1'b0, request_mask_reg,
                                           trigger_sensitivity_reg};
            `KAW_IDX_ENABLE:      rd_byte = {1'b0, wake_irq_enable_reg, pin_en_reg};
            `KAW_IDX_IRQ_STATUS:  rd_byte = {6'h00, irq_status_reg};
            `KAW_IDX_IRQ_MASK:    rd_byte = {6'h00, irq_mask_reg};
            `KAW_IDX_WAKE_CFG:    rd_byte = {7'h00, wake_period_select_reg};
            `KAW_IDX_PIN_IN:      rd_byte = {2'b00, key_pin};
            default:              rd_byte = 8'h00;
        endcase
    end
    // Bit six of port data has no pin, direction or pullup behind it

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    reg         rvalid_next;
    reg  [31:0] rdata_next;
    reg  [1:0]  rresp_next;

    // Read-to-clear uses the acceptance edge, so rdata holds the pre-clear value
    always @*
    begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rd_take)
        begin
            rvalid_next = 1'b1;
            rdata_next  = {24'h00_0000, rd_byte};
            rresp_next  = resp_for(rd_idx);
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= 2'b00;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

endmodule // kaw_keypad_wake

// *** core/kaw_regs.vh ***
// Register offsets, field positions, reset values and timing counts for the keypad/wake block
`ifndef KAW_REGS_VH
`define KAW_REGS_VH

// Printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define KAW_IDX_PORT_DATA      8'h00
`define KAW_IDX_STATUS_CTRL    8'h1a
`define KAW_IDX_ENABLE         8'h1b
`define KAW_IDX_IRQ_STATUS     8'h20
`define KAW_IDX_IRQ_MASK       8'h21
`define KAW_IDX_WAKE_CFG       8'h22
`define KAW_IDX_PIN_IN         8'h23

// key_status_control fields
`define KAW_SC_FLAG            3
`define KAW_SC_ACK             2
`define KAW_SC_MASK            1
`define KAW_SC_SENS            0

// key_and_wake_enable fields
`define KAW_EN_WAKE            6

// port_a_data_wake_latch field
`define KAW_PD_WAKE            6

// irq_status / irq_mask fields
`define KAW_IS_KEY             0
`define KAW_IS_WAKE            1

`define KAW_RST_STATUS_CTRL    8'h00
`define KAW_RST_ENABLE         8'h00
`define KAW_RST_WAKE_CFG       8'h00

// Wakeup timeouts in microseconds
`define KAW_SHORT_US           16000
`define KAW_LONG_US            512000
`define KAW_OSC_KHZ            32

`endif

// *** test/kaw_key_model.sv ***
// Key switch model on the keypad pins
`timescale 1ns/1ps
module kaw_key_model (
    input  wire logic [5:0] press,
    input  wire logic       clk,
    input  wire logic [5:0] pull_en,
    output logic      [5:0] key_pin
);
    initial key_pin = 6'h3f;
    // Pressed pin shorts low; released pin rests on pullup, else floats and toggles
    always @(posedge clk)
        key_pin <= ~press & (pull_en | ~key_pin);
endmodule // kaw_key_model

// *** test/kaw_keypad_wake_props.sv ***
// Port checker for the keypad/wake block
`timescale 1ns/1ps
module kaw_keypad_wake_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [5:0]  key_pullup_en,
    input wire logic        cpu_irq,
    input wire logic        wake_from_stop,
    input wire logic        irq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    same_wake_a: assert property (cpu_irq == wake_from_stop)
        else $error("wake output differs");
    rst_quiet_a: assert property (disable iff (1'b0) reset |=> !cpu_irq && !irq)
        else $error("request after reset");
    // Pin enables only move when software writes
    pull_cause_a: assert property ($changed(key_pullup_en) |-> $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2)) else $error("pullup moved");
    // cpu_irq drops only through ack or mask writes, up to three edges late
    irq_drop_a: assert property ($fell(cpu_irq) |-> $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3)) else $error("request dropped");
    bresp_next_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("no write response");
    bblock_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken");
    rdata_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    rupper_zero_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 0)
        else $error("read lane or ready wrong");
    cover property ($rose(cpu_irq));
    cover property ($rose(irq));
    cover property ($fell(cpu_irq));
endmodule // kaw_keypad_wake_props
bind kaw_keypad_wake kaw_keypad_wake_props u_kaw_keypad_wake_props (.*);

// *** test/kaw_keypad_wake_tb_top.sv ***
// Self-checking bench for the keypad/wake block
`timescale 1ns/1ps
`include "kaw_regs.vh"
module kaw_keypad_wake_tb_top;
    localparam [7:0] SC = `KAW_IDX_STATUS_CTRL, EN = `KAW_IDX_ENABLE, PD = `KAW_IDX_PORT_DATA;
    localparam [7:0] IS = `KAW_IDX_IRQ_STATUS, IM = `KAW_IDX_IRQ_MASK, WC = `KAW_IDX_WAKE_CFG;
    logic        clk = 0, reset = 1;
    logic [5:0]  press = 0, en;
    wire  [5:0]  key_pin, key_pullup_en;
    wire         cpu_irq, wake_from_stop, irq, s_axi_awready, s_axi_wready;
    wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  d;
    logic [1:0]  r;
    int          err_count = 0, total_checks = 0;
    always #2 clk = ~clk;
    // Short oscillator counts keep wake periods at 8 and 16 clocks
    kaw_keypad_wake #(.OSC_DIV(2), .SHORT_TICKS(4), .LONG_TICKS(8)) u_kaw_keypad_wake (.*);
    kaw_key_model u_kaw_key_model (.clk(clk), .press(press), .pull_en(key_pullup_en),
        .key_pin(key_pin));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic [7:0] sc(input f, input m, input s);
        sc = {4'h0, f, 1'b0, m, s};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Upper lanes carry noise, only lane 0 may land
    task automatic wr(input [7:0] i, input [7:0] v);
        logic a, w;
        @(posedge clk);
        a = 1;
        w = 1;
        s_axi_awaddr <= {2'b00, i, 2'b00};
        s_axi_wdata <= ($urandom << 8) | v;
        s_axi_wstrb <= 4'($urandom) | 4'h1;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (a || w)
        begin
            @(posedge clk);
            if (s_axi_awready) a = 0;
            if (s_axi_wready) w = 0;
            s_axi_awvalid <= a;
            s_axi_wvalid <= w;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rdc(input [7:0] i, input [7:0] m, input [7:0] e);
        @(posedge clk);
        s_axi_araddr <= {2'b00, i, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata[7:0];
        s_axi_rready <= 0;
        chk(d & m, e);
    endtask
    task automatic end_of_test;
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_count++;
        end_of_test;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hce51ded4));
        repeat (16) @(posedge clk);
        reset <= 0;
        rdc(SC, 8'hff, 8'h00);
        rdc(EN, 8'hff, 8'h00);
        rdc(PD, 8'h40, 8'h00);
        wr(8'h40, 8'h00);
        chk(r, 2'b10);
        wr(IM, 8'h01);
        for (int k = 0; k < 6; k++)
        begin
            en = 6'($urandom) | (6'h01 << k);
            wr(EN, {2'b00, en});
            chk(key_pullup_en, en);
            wr(SC, sc(0, 0, 0));
            press <= 6'h01 << k;
            repeat (6) @(posedge clk);
            chk(cpu_irq, 1);
            chk(irq, 1);
            rdc(SC, 8'hff, sc(1, 0, 0));
            rdc(IS, 8'h01, 8'h01);
            repeat (2) @(posedge clk);
            chk(irq, 0);
            wr(SC, 8'h04);
            rdc(SC, 8'hff, sc(0, 0, 0));
            wr(SC, 8'h05);
            rdc(SC, 8'hff, sc(1, 0, 1));
            wr(SC, 8'h03);
            rdc(SC, 8'hff, sc(1, 1, 1));
            chk(cpu_irq, 0);
            press <= 0;
            wr(SC, 8'h05);
            rdc(SC, 8'hff, sc(0, 0, 1));
            wr(EN, {2'b00, ~(6'h01 << k)});
            wr(SC, 8'h04);
            press <= 6'h01 << k;
            repeat (6) @(posedge clk);
            rdc(SC, 8'h08, 8'h00);
            press <= 0;
            wr(EN, 8'h00);
        end
        for (int p = 0; p < 2; p++)
        begin
            wr(WC, 8'(p));
            wr(SC, 8'h04 | 8'(p));
            wr(EN, 8'h40);
            repeat (40) @(posedge clk);
            rdc(PD, 8'h40, 8'h40);
            rdc(SC, 8'h08, 8'h08);
            chk(wake_from_stop, 1);
            wr(EN, 8'h00);
            wr(SC, 8'h04 | 8'(p));
            rdc(PD, 8'h40, 8'h00);
            repeat (40) @(posedge clk);
            rdc(PD, 8'h40, 8'h00);
        end
        end_of_test;
    end
endmodule // kaw_keypad_wake_tb_top
